/* File: rfc_rx_ctrl.sv */
// Summary of operation
// - Control bit 6 enables automatic sync loss
// - Writing control bit 5 clears CRC counter
// - Writing control bit 4 clears pattern flag
// - Control bit 3 picks ones or zeros
// - Control bit 2 adds stuff bit check
// - Control bit 1 holds realignment while set
// - Control bit 0 clears and blocks frame interrupt
// - Test bit 2 halts DS1 counter eight receive clocks
// - Test bit 1 blocks receive FIFO writes
// - Water level is write minus read pointer
// - Level spans 0 to 120, half bits
// - Stuff indicators refresh each frame interrupt
// - Status bits 5,4 flag FIFO misalignment
// - Status bits 3..0 flag under/overflow
// - Sync after two good, loss after five bad
// - Frame event rises, frame-correct updated each frame
// - Pattern flag after 64 matching bits
`include "rfc_params.svh"
`default_nettype none
module rfc_rx_ctrl #(
    parameter int PTR_W = 8                   // FIFO pointer width, half-bit units
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic [7:0]         bus_addr,      // Processor address
    input  wire logic [7:0]         bus_wdata,     // Processor write data
    input  wire logic               bus_wr,        // One-cycle write strobe
    input  wire logic               bus_rd,        // One-cycle read strobe
    output logic      [7:0]         bus_rdata_q,   // Read data, one cycle after strobe
    input  wire logic               rx_bit_en,     // Receive clock enable
    input  wire logic               rx_bit,        // Received payload bit
    input  wire logic               frame_tick,    // 6 ms receive frame boundary
    input  wire rfc_pkg::rfc_frame_t frame_in,     // Qualifiers of the ending frame
    input  wire rfc_pkg::rfc_fifo_evt_t fifo_evt,  // FIFO fault pulses
    input  wire logic [PTR_W-1:0]   fifo_wr_ptr,   // Receive FIFO write pointer
    input  wire logic [PTR_W-1:0]   fifo_rd_ptr,   // Receive FIFO read pointer
    input  wire logic               fifo_wr_req,   // Datapath wants a FIFO write
    output logic                    fifo_wr_en_q,  // Gated FIFO write
    output logic                    ds1_halt_q,    // DS1 counter hold
    output logic                    crc_clr_q,     // CRC error counter clear pulse
    output logic                    realign_q,     // Discard alignment
    output logic                    sync_q,        // Frame sync declared
    output logic                    frame_event_q, // Frame event flag
    output logic                    frame_ok_q,    // Frame-correct flag
    output logic                    frame_irq_q,   // Pending frame interrupt
    output logic                    pat_flag_q     // Pattern detection flag
);

    // Register decode strobes
    logic wr_ctrl;
    logic wr_test;
    assign wr_ctrl = bus_wr && (bus_addr == `RFC_ADDR_CTRL);
    assign wr_test = bus_wr && (bus_addr == `RFC_ADDR_TEST);

    // ---------------- Register file state ----------------
    logic [7:0]            ctrl_q, ctrl_d;    // Control byte
    logic                  blk_q, blk_d;      // Latched FIFO write block
    logic [7:0]            rdata_d;           // Next read data
    logic [7:0]            level_q, level_d;  // Water level snapshot
    logic [1:0]            stuff_q, stuff_d;  // Stuff indicators
    rfc_pkg::rfc_fifo_evt_t err_q, err_d;     // Sticky FIFO faults
    logic                  crc_clr_d;

    // Water level; pointers wrap at twice the depth in half-bit units
    logic [PTR_W-1:0] diff;
    always_comb begin
        diff = fifo_wr_ptr - fifo_rd_ptr;
        if (fifo_wr_ptr < fifo_rd_ptr) begin
            diff = diff + PTR_W'(`RFC_LVL_SPAN);
        end
    end

    // Register next values
    always_comb begin
        ctrl_d    = ctrl_q;
        blk_d     = blk_q;
        crc_clr_d = 1'b0;
        level_d   = 8'(diff);
        stuff_d   = stuff_q;
        err_d     = err_q | fifo_evt;
        // Reserved bits masked; software must write them as zero anyway
        if (wr_ctrl) begin
            ctrl_d    = bus_wdata & `RFC_CTRL_MASK;
            crc_clr_d = bus_wdata[`RFC_C_CRCCLR];
        end
        if (wr_test) begin
            blk_d = bus_wdata[`RFC_T_WRBLK];
        end
        // Indicators sampled at the frame interrupt
        if (frame_tick) begin
            stuff_d = {frame_in.stuff_ind1, frame_in.stuff_ind2};
        end
        // Read mux; level, depth status ignore writes
        rdata_d = bus_rdata_q;
        if (bus_rd) begin
            if (bus_addr == `RFC_ADDR_CTRL) begin
                rdata_d = ctrl_q;
            end else if (bus_addr == `RFC_ADDR_TEST) begin
                rdata_d = {6'h00, blk_q, 1'b0};
            end else if (bus_addr == `RFC_ADDR_LEVEL) begin
                rdata_d = level_q;
            end else if (bus_addr == `RFC_ADDR_DEPTH) begin
                rdata_d = {stuff_q, err_q};
            end else begin
                rdata_d = `RFC_BYTE_ZERO;
            end
        end
    end

    // Register flops
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctrl_q      <= `RFC_CTRL_RST;
            blk_q       <= 1'b0;
            bus_rdata_q <= `RFC_BYTE_ZERO;
            level_q     <= `RFC_BYTE_ZERO;
            stuff_q     <= 2'h0;
            err_q       <= '0;
            crc_clr_q   <= 1'b0;
        end else begin
            ctrl_q      <= ctrl_d;
            blk_q       <= blk_d;
            bus_rdata_q <= rdata_d;
            level_q     <= level_d;
            stuff_q     <= stuff_d;
            err_q       <= err_d;
            crc_clr_q   <= crc_clr_d;
        end
    end

    // ---------------- DS1 hold and FIFO gate ----------------
    logic [3:0] halt_q, halt_d;   // Remaining held receive clocks
    logic       ds1_halt_d;
    logic       fifo_wr_en_d;

    // Not latched: one write arms a fixed-length hold
    always_comb begin
        halt_d = halt_q;
        if (wr_test && bus_wdata[`RFC_T_HALT]) begin
            halt_d = `RFC_HALT_CYC;
        end else if (rx_bit_en && (halt_q != 4'h0)) begin
            halt_d = halt_q - 4'h1;
        end
        ds1_halt_d   = (halt_d != 4'h0);
        fifo_wr_en_d = fifo_wr_req && !blk_q;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            halt_q       <= 4'h0;
            ds1_halt_q   <= 1'b0;
            fifo_wr_en_q <= 1'b0;
        end else begin
            halt_q       <= halt_d;
            ds1_halt_q   <= ds1_halt_d;
            fifo_wr_en_q <= fifo_wr_en_d;
        end
    end

    // ---------------- Pattern detector ----------------
    logic [6:0] run_q, run_d;    // Consecutive matching bits
    logic       pat_d;
    logic       pat_hit;

    // Run restarts on any mismatch and on a type change, so a new type needs a fresh 64
    always_comb begin
        run_d   = run_q;
        pat_hit = 1'b0;
        if (rx_bit_en) begin
            if (rx_bit == ctrl_q[`RFC_C_PATONES]) begin
                if (run_q != `RFC_PAT_LEN) begin
                    run_d = run_q + 7'h1;
                end
            end else begin
                run_d = 7'h0;
            end
        end
        // New pattern type: a run counted for the old type must not carry over
        if (wr_ctrl && (bus_wdata[`RFC_C_PATONES] != ctrl_q[`RFC_C_PATONES])) begin
            run_d = 7'h0;
        end
        // Set on every received bit while the run is saturated, so a clear holds only until the next matching bit
        pat_hit = rx_bit_en && (run_d == `RFC_PAT_LEN);
        pat_d   = pat_flag_q;
        if (wr_ctrl && bus_wdata[`RFC_C_PATCLR]) begin
            pat_d = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (pat_hit) begin
            pat_d = 1'b1;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            run_q      <= 7'h0;
            pat_flag_q <= 1'b0;
        end else begin
            run_q      <= run_d;
            pat_flag_q <= pat_d;
        end
    end

    // ---------------- Frame sync and interrupt ----------------
    rfc_pkg::rfc_sync_t st_q, st_d;   // Alignment state
    logic [2:0] bad_q, bad_d;         // Consecutive bad frames
    logic       good;                 // Sync word qualified
    logic       ev_d, ok_d, irq_d, sync_d;

    assign good = frame_in.sync_ok &&
                  (frame_in.stuff_ok || !ctrl_q[`RFC_C_STUFFQ]);

    always_comb begin
        st_d  = st_q;
        bad_d = bad_q;
        ev_d  = frame_event_q;
        ok_d  = frame_ok_q;
        irq_d = frame_irq_q;
        if (frame_tick) begin
            case (st_q)
                rfc_pkg::RFC_HUNT: begin
                    if (good) st_d = rfc_pkg::RFC_CONFIRM;
                end
                rfc_pkg::RFC_CONFIRM: begin
                    st_d = good ? rfc_pkg::RFC_LOCKED : rfc_pkg::RFC_HUNT;
                    bad_d = 3'h0;
                end
                rfc_pkg::RFC_LOCKED: begin
                    // Without auto loss, software watches frame_ok
                    if (frame_in.bits_ok) begin
                        bad_d = 3'h0;
                    end else if (ctrl_q[`RFC_C_AUTOLOSS]) begin
                        bad_d = bad_q + 3'h1;
                        if (bad_d == `RFC_LOSS_FRAMES) begin
                            st_d = rfc_pkg::RFC_HUNT;
                        end
                    end
                end
                default: st_d = rfc_pkg::RFC_HUNT;
            endcase
            ev_d  = 1'b1;
            ok_d  = frame_in.bits_ok;
            irq_d = 1'b1;
        end
        // Held high: alignment dropped until software lowers the bit
        if (ctrl_q[`RFC_C_REALIGN]) begin
            st_d  = rfc_pkg::RFC_HUNT;
            bad_d = 3'h0;
        end
        // Interrupt gate dominates frame ticks
        if (ctrl_q[`RFC_C_IRQOFF]) begin
            ev_d  = 1'b0;
            ok_d  = 1'b0;
            irq_d = 1'b0;
        end
        sync_d = (st_d == rfc_pkg::RFC_LOCKED);
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st_q          <= rfc_pkg::RFC_HUNT;
            bad_q         <= 3'h0;
            frame_event_q <= 1'b0;
            frame_ok_q    <= 1'b0;
            frame_irq_q   <= 1'b0;
            sync_q        <= 1'b0;
            realign_q     <= 1'b0;
        end else begin
            st_q          <= st_d;
            bad_q         <= bad_d;
            frame_event_q <= ev_d;
            frame_ok_q    <= ok_d;
            frame_irq_q   <= irq_d;
            sync_q        <= sync_d;
            realign_q     <= ctrl_q[`RFC_C_REALIGN];
        end
    end

    // ---------------- Checks ----------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_crc_clr_pulse: assert property (wr_ctrl && bus_wdata[`RFC_C_CRCCLR]
        |=> crc_clr_q ##1 !crc_clr_q) else $error("crc clear not one pulse");
    a_pat_clear: assert property (wr_ctrl && bus_wdata[`RFC_C_PATCLR] && !pat_hit
        |=> !pat_flag_q) else $error("pattern flag not cleared");
    a_irq_gate: assert property (ctrl_q[`RFC_C_IRQOFF]
        |=> !frame_irq_q && !frame_event_q) else $error("frame irq not gated");
    a_halt_len: assert property (wr_test && bus_wdata[`RFC_T_HALT]
        |=> ds1_halt_q && halt_q == `RFC_HALT_CYC) else $error("ds1 hold not armed");
    a_wr_block: assert property (blk_q |=> !fifo_wr_en_q)
        else $error("fifo write not blocked");
    a_level_span: assert property (level_q <= `RFC_LVL_SPAN)
        else $error("water level out of span");
    a_stuff_upd: assert property (frame_tick
        |=> stuff_q == $past({frame_in.stuff_ind1, frame_in.stuff_ind2}))
        else $error("stuff indicators stale");
    a_err_sticky: assert property ((($past(err_q) & ~err_q) == '0))
        else $error("fifo fault flag fell");
    a_sync_hold: assert property (sync_q && !ctrl_q[`RFC_C_AUTOLOSS]
        && !ctrl_q[`RFC_C_REALIGN] |=> sync_q) else $error("sync dropped");
    a_frame_event: assert property (frame_tick && !ctrl_q[`RFC_C_IRQOFF]
        |=> frame_event_q && frame_irq_q) else $error("frame event missed");

endmodule // rfc_rx_ctrl
`default_nettype wire

/* File: rfc_params.svh */
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH

// Register addresses on the 8-bit processor port
`define RFC_ADDR_CTRL   8'hC0
`define RFC_ADDR_TEST   8'hC1
`define RFC_ADDR_LEVEL  8'hC2
`define RFC_ADDR_DEPTH  8'hC3

// Reset values
`define RFC_CTRL_RST    8'h00
`define RFC_TEST_RST    8'h00
`define RFC_BYTE_ZERO   8'h00

// Control register bit positions
`define RFC_C_AUTOLOSS  6
`define RFC_C_CRCCLR    5
`define RFC_C_PATCLR    4
`define RFC_C_PATONES   3
`define RFC_C_STUFFQ    2
`define RFC_C_REALIGN   1
`define RFC_C_IRQOFF    0
// Writable control bits; bit 7 reserved
`define RFC_CTRL_MASK   8'h7F

// Test register bit positions
`define RFC_T_HALT      2
`define RFC_T_WRBLK     1

// Timing and pattern counts
`define RFC_PAT_LEN     7'h40
`define RFC_LOSS_FRAMES 3'h5
`define RFC_HALT_CYC    4'h8
`define RFC_LVL_SPAN    8'h78

`endif

/* File: rfc_pkg.sv */
`default_nettype none
package rfc_pkg;

    // Frame alignment states
    typedef enum logic [1:0] {
        RFC_HUNT,
        RFC_CONFIRM,
        RFC_LOCKED
    } rfc_sync_t;

    // FIFO fault events, bit order of the depth status register
    typedef struct packed {
        logic mis_rx;
        logic mis_tx;
        logic unf_rx;
        logic ovf_rx;
        logic unf_tx;
        logic ovf_tx;
    } rfc_fifo_evt_t;

    // Per-frame qualifiers from the framing datapath
    typedef struct packed {
        logic sync_ok;
        logic stuff_ok;
        logic bits_ok;
        logic stuff_ind1;
        logic stuff_ind2;
    } rfc_frame_t;

endpackage
`default_nettype wire

/* File: rfc_cpu_model.sv */
`include "rfc_params.svh"
`default_nettype none
// Processor side of the 8-bit register port
module rfc_cpu_model (
    input  wire logic       core_clk,
    output logic      [7:0] bus_addr,
    output logic      [7:0] bus_wdata,
    output logic            bus_wr,
    output logic            bus_rd,
    input  wire logic [7:0] bus_rdata_q
);
    timeunit 1ns;
    timeprecision 1ps;

    // Bus idle from time zero
    initial begin
        bus_addr  = 8'h00;
        bus_wdata = 8'h00;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
    end

    // One-cycle write strobe; reserved control and test bits sent as zero, other addresses unmasked
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_addr  <= a;
        bus_wdata <= (a == `RFC_ADDR_CTRL) ? (d & 8'h7F) :
                     (a == `RFC_ADDR_TEST) ? (d & 8'h06) : d;
        bus_wr    <= 1'b1;
        @(posedge core_clk);
        bus_wr    <= 1'b0;
        // Stale data must not look valid once the strobe is gone
        bus_wdata <= ~bus_wdata;
        #1;
    endtask

    // One-cycle read strobe, data taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge core_clk);
        bus_rd   <= 1'b0;
        #1;
        d = bus_rdata_q;
    endtask
endmodule // rfc_cpu_model
`default_nettype wire

/* File: tb_top.sv */
`include "rfc_params.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   core_clk, rst, rx_bit_en, rx_bit, frame_tick, fifo_wr_req;
    logic [7:0]             bus_addr, bus_wdata, bus_rdata_q, fifo_wr_ptr, fifo_rd_ptr;
    logic                   bus_wr, bus_rd, fifo_wr_en_q, ds1_halt_q, crc_clr_q, realign_q;
    logic                   sync_q, frame_event_q, frame_ok_q, frame_irq_q, pat_flag_q;
    rfc_pkg::rfc_frame_t    frame_in;      // Frame qualifiers
    rfc_pkg::rfc_fifo_evt_t fifo_evt;      // Fault pulses
    int                     fails, tests_run, cyc;

    rfc_rx_ctrl i_rfc_rx_ctrl (.core_clk(core_clk), .rst(rst), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q),
        .rx_bit_en(rx_bit_en), .rx_bit(rx_bit), .frame_tick(frame_tick), .frame_in(frame_in),
        .fifo_evt(fifo_evt), .fifo_wr_ptr(fifo_wr_ptr), .fifo_rd_ptr(fifo_rd_ptr),
        .fifo_wr_req(fifo_wr_req), .fifo_wr_en_q(fifo_wr_en_q), .ds1_halt_q(ds1_halt_q),
        .crc_clr_q(crc_clr_q), .realign_q(realign_q), .sync_q(sync_q),
        .frame_event_q(frame_event_q), .frame_ok_q(frame_ok_q), .frame_irq_q(frame_irq_q),
        .pat_flag_q(pat_flag_q));

    rfc_cpu_model i_rfc_cpu_model (.core_clk(core_clk), .bus_addr(bus_addr),
        .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata_q(bus_rdata_q));

    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // Single compare point, counts every check
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    // Register read with expected byte
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        logic [7:0] d;
        i_rfc_cpu_model.rd(a, d);
        chk(n, d, e);
    endtask

    // Packed view: sync, event, irq, frame-correct, pattern
    task automatic flags(input logic [7:0] e);
        chk("flags", {3'h0, sync_q, frame_event_q, frame_irq_q, frame_ok_q, pat_flag_q}, e);
    endtask

    // One frame boundary pulse with its qualifiers
    task automatic tick(input logic [4:0] f);
        @(posedge core_clk);
        frame_tick <= 1'b1;
        frame_in   <= f;
        @(posedge core_clk);
        frame_tick <= 1'b0;
        #1;
    endtask

    // Receive bits, one enable pulse every other cycle
    task automatic pulse(input logic b, input int n);
        repeat (n) begin
            @(posedge core_clk);
            rx_bit_en <= 1'b1;
            rx_bit    <= b;
            @(posedge core_clk);
            rx_bit_en <= 1'b0;
        end
        #1;
    endtask

    task automatic conclude();
        if (fails == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Hang guard, well above the roughly 415 cycles needed
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        rst = 1'b1;
        rx_bit_en = 1'b0;
        rx_bit = 1'b0;
        frame_tick = 1'b0;
        frame_in = '0;
        fifo_evt = '0;
        fifo_wr_ptr = 8'h46;
        fifo_rd_ptr = 8'h0A;
        fifo_wr_req = 1'b1;
        fails = 0;
        tests_run = 0;
        cyc = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        #1;
        flags(8'h00);
        rchk("control", `RFC_ADDR_CTRL, 8'h00);
        rchk("test", `RFC_ADDR_TEST, 8'h00);
        rchk("level", `RFC_ADDR_LEVEL, 8'h3C);
        rchk("unmapped", 8'hC7, 8'h00);
        // Counter clear is a single pulse
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h20);
        chk("crc clear", {7'h00, crc_clr_q}, 8'h01);
        @(posedge core_clk);
        #1;
        chk("crc clear", {7'h00, crc_clr_q}, 8'h00);
        rchk("control", `RFC_ADDR_CTRL, 8'h20);
        // Level wraps across the end of the pointer span
        @(posedge core_clk);
        fifo_wr_ptr <= 8'h05;
        fifo_rd_ptr <= 8'h64;
        i_rfc_cpu_model.wr(`RFC_ADDR_LEVEL, 8'hFF);
        rchk("level", `RFC_ADDR_LEVEL, 8'h19);
        // Each fault lands on its own bit and stays
        for (int i = 0; i < 6; i++) begin
            @(posedge core_clk);
            fifo_evt <= 6'(1 << i);
            @(posedge core_clk);
            fifo_evt <= '0;
            rchk("depth", `RFC_ADDR_DEPTH, 8'((2 << i) - 1));
        end
        i_rfc_cpu_model.wr(`RFC_ADDR_DEPTH, 8'h00);
        rchk("depth", `RFC_ADDR_DEPTH, 8'h3F);
        // Stuff-checked sync: bad stuff bits never lock
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h04);
        tick(5'h14);
        tick(5'h14);
        flags(8'h0E);
        tick(5'h1E);
        flags(8'h0E);
        tick(5'h1E);
        flags(8'h1E);
        rchk("depth", `RFC_ADDR_DEPTH, 8'hBF);
        rchk("level", `RFC_ADDR_LEVEL, 8'h19);
        // Software loss mode keeps sync through bad frames
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h00);
        repeat (5) tick(5'h18);
        flags(8'h1C);
        // Automatic loss drops on the fifth bad frame only
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h40);
        repeat (4) tick(5'h18);
        flags(8'h1C);
        tick(5'h18);
        flags(8'h0C);
        // Interrupt gate clears and blocks, then reopens
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h41);
        @(posedge core_clk);
        #1;
        flags(8'h00);
        tick(5'h1C);
        flags(8'h00);
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h40);
        tick(5'h1D);
        flags(8'h1E);
        rchk("depth", `RFC_ADDR_DEPTH, 8'h7F);
        // Realign holds hunt until the bit returns to zero
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h42);
        @(posedge core_clk);
        #1;
        chk("realign", {7'h00, realign_q}, 8'h01);
        tick(5'h1C);
        tick(5'h1C);
        flags(8'h0E);
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h40);
        tick(5'h1C);
        tick(5'h1C);
        flags(8'h1E);
        // Pattern needs the full 64-bit run
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h08);
        pulse(1'b1, 63);
        flags(8'h1E);
        pulse(1'b1, 1);
        flags(8'h1F);
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h18);
        flags(8'h1E);
        i_rfc_cpu_model.wr(`RFC_ADDR_CTRL, 8'h10);
        pulse(1'b0, 63);
        flags(8'h1E);
        pulse(1'b0, 1);
        flags(8'h1F);
        // Counter hold lasts exactly eight receive bits
        i_rfc_cpu_model.wr(`RFC_ADDR_TEST, 8'h04);
        chk("halt", {7'h00, ds1_halt_q}, 8'h01);
        pulse(1'b0, 7);
        chk("halt", {7'h00, ds1_halt_q}, 8'h01);
        pulse(1'b0, 1);
        chk("halt", {7'h00, ds1_halt_q}, 8'h00);
        rchk("test", `RFC_ADDR_TEST, 8'h00);
        // FIFO write gate
        chk("fifo write", {7'h00, fifo_wr_en_q}, 8'h01);
        i_rfc_cpu_model.wr(`RFC_ADDR_TEST, 8'h02);
        @(posedge core_clk);
        #1;
        chk("fifo write", {7'h00, fifo_wr_en_q}, 8'h00);
        rchk("test", `RFC_ADDR_TEST, 8'h02);
        i_rfc_cpu_model.wr(`RFC_ADDR_TEST, 8'h00);
        @(posedge core_clk);
        #1;
        chk("fifo write", {7'h00, fifo_wr_en_q}, 8'h01);
        conclude();
    end
endmodule // tb_top
`default_nettype wire
